// [hw/ait_pkg.sv]
package ait_pkg;
	// Clock rate and the idle power-down tick
	localparam int unsigned AIT_CLK_HZ    = 10_000_000;
	localparam int unsigned AIT_TICK_MS   = 5;
	localparam int unsigned AIT_TICK_CYC  = AIT_CLK_HZ / 1000 * AIT_TICK_MS;
	// Command opcodes
	localparam logic [7:0]  AIT_OP_IDLE_A = 8'h97;
	localparam logic [7:0]  AIT_OP_IDLE_B = 8'hE3;
	localparam logic [7:0]  AIT_OP_IMM_A  = 8'h95;
	localparam logic [7:0]  AIT_OP_IMM_B  = 8'hE1;
	localparam logic [7:0]  AIT_OP_INIT   = 8'h91;
	localparam logic [7:0]  AIT_OP_NOP    = 8'h00;
	localparam logic [7:0]  AIT_OP_RDBUF  = 8'hE4;
	localparam logic [7:0]  AIT_OP_RDDMA  = 8'hC8;
	// Register word indices on the Avalon bus
	localparam logic [3:0]  AIT_REG_CMD   = 4'h0;
	localparam logic [3:0]  AIT_REG_SCNT  = 4'h1;
	localparam logic [3:0]  AIT_REG_SNUM  = 4'h2;
	localparam logic [3:0]  AIT_REG_CYLO  = 4'h3;
	localparam logic [3:0]  AIT_REG_CYHI  = 4'h4;
	localparam logic [3:0]  AIT_REG_DRHD  = 4'h5;
	localparam logic [3:0]  AIT_REG_FEAT  = 4'h6;
	localparam logic [3:0]  AIT_REG_STAT  = 4'h7;
	localparam logic [3:0]  AIT_REG_ERR   = 4'h8;
	localparam logic [3:0]  AIT_REG_DATA  = 4'h9;
	localparam logic [3:0]  AIT_REG_ID163 = 4'hA;
	localparam logic [3:0]  AIT_REG_ID164 = 4'hB;
	localparam logic [3:0]  AIT_REG_MODE  = 4'hC;
	localparam logic [3:0]  AIT_REG_GEOM  = 4'hD;
	localparam logic [3:0]  AIT_REG_DLBA  = 4'hE;
	localparam logic [3:0]  AIT_REG_DCNT  = 4'hF;
	// Status and error bit positions
	localparam int unsigned AIT_ST_ERR    = 0;
	localparam int unsigned AIT_ST_DRQ    = 3;
	localparam int unsigned AIT_ST_DRDY   = 6;
	localparam int unsigned AIT_ST_BSY    = 7;
	localparam int unsigned AIT_ST_IDLE   = 8;
	localparam int unsigned AIT_ST_STBY   = 9;
	localparam int unsigned AIT_ST_APD    = 10;
	localparam int unsigned AIT_ER_ABRT   = 2;
	// Mode register write layout
	localparam int unsigned AIT_MD_PIO    = 0;
	localparam int unsigned AIT_MD_MDMA   = 3;
	localparam int unsigned AIT_MD_UDMA   = 6;
	// Identify word 163 and 164 field values, and the highest accepted UDMA mode
	localparam logic [2:0]  AIT_PIO_CAP   = 3'h2;
	localparam logic [2:0]  AIT_MDMA_CAP  = 3'h2;
	localparam logic [2:0]  AIT_IO_CAP    = 3'h3;
	localparam logic [2:0]  AIT_MEM_CAP   = 3'h3;
	localparam logic [2:0]  AIT_UDMA_MAX  = 3'h5;
	localparam logic [3:0]  AIT_W163_RSV  = 4'h0;
	localparam logic [9:0]  AIT_W164_RSV  = 10'h000;
	// Buffer sizes
	localparam int unsigned AIT_BUF_WORDS = 256;
	localparam int unsigned AIT_FIFO_W    = 16;
	localparam int unsigned AIT_FIFO_D    = 16;
	localparam logic [8:0]  AIT_FULL_CNT  = 9'h100;
	// Task file contents
	typedef struct packed {
		logic [7:0] feat;
		logic [7:0] scnt;
		logic [7:0] snum;
		logic [7:0] cylo;
		logic [7:0] cyhi;
		logic [7:0] drhd;
	} ait_tf_t;
	// DMA read request handed to the transfer engine
	typedef struct packed {
		logic [27:0] lba;
		logic [8:0]  cnt;
	} ait_dma_t;
	// Selected transfer modes, 0 means none or the older word
	typedef struct packed {
		logic [2:0] udma;
		logic [2:0] mdma;
		logic [2:0] pio;
	} ait_mode_t;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_XFER = 2'b11, ST_FIN = 2'b10} ait_state_t;
	typedef enum logic [1:0] {PW_ACTIVE = 2'b00, PW_IDLE = 2'b01, PW_STBY = 2'b11} ait_pwr_t;
endpackage : ait_pkg

// [hw/ait_top.sv]
// Operation
// - Word 163 bits 2-0: highest advanced PIO
// - Word 163 bits 5-3: highest advanced MDMA
// - Word 163 bits 8-6: selected advanced PIO
// - Word 163 bits 11-9: selected advanced MDMA
// - Word 163 top four bits reserved zero
// - Word 164 bits 2-0: fastest I/O cycle
// - Word 164 bits 5-3 memory cycle, rest reserved
// - Idle: busy, idle state, unbusy, interrupt
// - Idle Immediate: same sequence, parameters ignored
// - Nonzero count arms power-down, 5 ms ticks
// - Zero count disables automatic power-down
// - Geometry from sector count and head field
// - Geometry ignores cylinder, sector, feature registers
// - NOP always ends with command aborted
// - Read Buffer streams sector buffer, PIO in
// - Read DMA takes 28-bit address and count
// - Never UDMA and MDMA selected together
`timescale 1ns/1ps
module ait_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 16
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];          // Storage words
	logic [AW:0]      wr_ptr_r;             // Write pointer with wrap bit
	logic [AW:0]      rd_ptr_r;             // Read pointer with wrap bit
	logic             push;                 // Word accepted
	logic             pop;                  // Word drained

	// Extra pointer bit tells full from empty without a counter
	assign in_ready  = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
	assign out_valid = wr_ptr_r != rd_ptr_r;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rd_ptr_r[AW-1:0]];

	// Storage has no reset, only the pointers matter
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr_r[AW-1:0]] <= in_data;
		end
	end

	// Pointer update
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule : ait_fifo

module ait_top #(
	parameter int unsigned TICK_CYC = ait_pkg::AIT_TICK_CYC
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst,
	// Avalon-MM slave
	input  wire logic [3:0]   avs_address,
	input  wire logic         avs_read,
	input  wire logic         avs_write,
	input  wire logic [31:0]  avs_writedata,
	input  wire logic [3:0]   avs_byteenable,
	output logic [31:0]       avs_readdata,
	output logic              avs_waitrequest,
	// Host side status
	output logic              host_intrq,
	output logic              dev_busy,
	output logic              pwr_idle,
	output logic              pwr_standby,
	// DMA engine request
	output logic              dma_start,
	output ait_pkg::ait_dma_t dma_req
);
	import ait_pkg::*;

	logic               ack_r;          // Second bus cycle, answer stands
	logic [31:0]        rdata_r;        // Registered read data
	logic [31:0]        rd_val;         // Decoded read value
	ait_tf_t            tf_r;           // Task file
	logic [7:0]         op_r;           // Latched opcode
	ait_state_t         state_r;        // Command sequencer
	ait_mode_t          mode_r;         // Selected transfer modes
	logic [7:0]         geo_sec_r;      // Sectors per track
	logic [4:0]         geo_head_r;     // Heads per cylinder
	logic               abrt_r;         // Command aborted
	logic               intrq_r;        // Host interrupt
	logic               intrq_nxt;
	ait_pwr_t           pwr_r;          // Power state
	logic               apd_en_r;       // Automatic power-down armed
	logic [7:0]         pd_left_r;      // Ticks left to standby
	logic [31:0]        tick_cnt_r;     // Cycles within one tick
	logic               tick;           // One tick elapsed
	logic [15:0]        buf_mem [AIT_BUF_WORDS]; // Sector buffer
	logic [7:0]         buf_wptr_r;     // Host fill position
	logic [7:0]         xfer_idx_r;     // Read Buffer position
	logic               dma_start_r;
	ait_dma_t           dma_req_r;
	logic               wr_hit;         // Write takes effect now
	logic               rd_hit;         // Read completes now
	logic               cmd_acc;        // Command accepted
	logic               fifo_in_ready;
	logic               fifo_out_valid;
	logic [15:0]        fifo_out_data;
	logic               fifo_push;
	logic               fifo_pop;

	// Identify word 163 from fixed capability and live selection
	function automatic logic [15:0] id163(input ait_mode_t m);
		id163 = {AIT_W163_RSV, m.mdma, m.pio, AIT_MDMA_CAP, AIT_PIO_CAP};
	endfunction : id163

	// Identify word 164, PC Card cycle capability
	function automatic logic [15:0] id164();
		id164 = {AIT_W164_RSV, AIT_MEM_CAP, AIT_IO_CAP};
	endfunction : id164

	// Both opcode pairs of the timed Idle
	function automatic logic is_idle(input logic [7:0] op);
		is_idle = (op == AIT_OP_IDLE_A) || (op == AIT_OP_IDLE_B);
	endfunction : is_idle

	// Both opcode pairs of Idle Immediate
	function automatic logic is_imm(input logic [7:0] op);
		is_imm = (op == AIT_OP_IMM_A) || (op == AIT_OP_IMM_B);
	endfunction : is_imm

	// One wait state: the answer always stands in the second cycle
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign wr_hit          = ack_r & avs_write & avs_byteenable[0];
	assign rd_hit          = ack_r & avs_read;
	assign cmd_acc         = wr_hit & (avs_address == AIT_REG_CMD) & (state_r == ST_IDLE);
	assign avs_readdata    = rdata_r;
	assign host_intrq      = intrq_r;
	assign dev_busy        = state_r == ST_EXEC;
	assign pwr_idle        = pwr_r == PW_IDLE;
	assign pwr_standby     = pwr_r == PW_STBY;
	assign dma_start       = dma_start_r;
	assign dma_req         = dma_req_r;
	assign tick            = tick_cnt_r == 32'(TICK_CYC - 1);
	assign fifo_push       = (state_r == ST_XFER) & fifo_in_ready;
	assign fifo_pop        = rd_hit & (avs_address == AIT_REG_DATA) & fifo_out_valid;

	// Bus handshake and read capture
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			ack_r <= (avs_read | avs_write) & ~ack_r;
			if (avs_read & ~ack_r) begin
				rdata_r <= rd_val;
			end
		end
	end

	// Read decode; unmapped and write-only words read zero
	always_comb begin
		rd_val = 32'h0000_0000;
		if (avs_address == AIT_REG_SCNT) begin
			rd_val[7:0] = tf_r.scnt;
		end else if (avs_address == AIT_REG_SNUM) begin
			rd_val[7:0] = tf_r.snum;
		end else if (avs_address == AIT_REG_CYLO) begin
			rd_val[7:0] = tf_r.cylo;
		end else if (avs_address == AIT_REG_CYHI) begin
			rd_val[7:0] = tf_r.cyhi;
		end else if (avs_address == AIT_REG_DRHD) begin
			rd_val[7:0] = tf_r.drhd;
		end else if (avs_address == AIT_REG_FEAT) begin
			rd_val[7:0] = tf_r.feat;
		end else if (avs_address == AIT_REG_STAT) begin
			rd_val[AIT_ST_BSY]  = dev_busy;
			rd_val[AIT_ST_DRDY] = ~dev_busy;
			rd_val[AIT_ST_DRQ]  = (state_r == ST_XFER) | fifo_out_valid;
			rd_val[AIT_ST_ERR]  = abrt_r;
			rd_val[AIT_ST_IDLE] = pwr_idle;
			rd_val[AIT_ST_STBY] = pwr_standby;
			rd_val[AIT_ST_APD]  = apd_en_r;
		end else if (avs_address == AIT_REG_ERR) begin
			rd_val[AIT_ER_ABRT] = abrt_r;
		end else if (avs_address == AIT_REG_DATA) begin
			rd_val[15:0] = fifo_out_valid ? fifo_out_data : 16'h0000;
		end else if (avs_address == AIT_REG_ID163) begin
			rd_val[15:0] = id163(mode_r);
		end else if (avs_address == AIT_REG_ID164) begin
			rd_val[15:0] = id164();
		end else if (avs_address == AIT_REG_MODE) begin
			rd_val[8:0] = mode_r;
		end else if (avs_address == AIT_REG_GEOM) begin
			rd_val[12:0] = {geo_head_r, geo_sec_r};
		end else if (avs_address == AIT_REG_DLBA) begin
			rd_val[27:0] = dma_req_r.lba;
		end else if (avs_address == AIT_REG_DCNT) begin
			rd_val[8:0] = dma_req_r.cnt;
		end
	end

	// Task file writes; frozen while busy so operands stay put
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tf_r <= '0;
		end else if (wr_hit && state_r != ST_EXEC) begin
			if (avs_address == AIT_REG_SCNT) begin
				tf_r.scnt <= avs_writedata[7:0];
			end else if (avs_address == AIT_REG_SNUM) begin
				tf_r.snum <= avs_writedata[7:0];
			end else if (avs_address == AIT_REG_CYLO) begin
				tf_r.cylo <= avs_writedata[7:0];
			end else if (avs_address == AIT_REG_CYHI) begin
				tf_r.cyhi <= avs_writedata[7:0];
			end else if (avs_address == AIT_REG_DRHD) begin
				tf_r.drhd <= avs_writedata[7:0];
			end else if (avs_address == AIT_REG_FEAT) begin
				tf_r.feat <= avs_writedata[7:0];
			end
		end
	end

	// Mode selection; a UDMA choice wins and clears MDMA
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mode_r <= '0;
		end else if (wr_hit && avs_address == AIT_REG_MODE && avs_byteenable[1]) begin
			// Reserved codes are refused and leave the field alone
			if (avs_writedata[AIT_MD_PIO +: 3] <= AIT_PIO_CAP) begin
				mode_r.pio <= avs_writedata[AIT_MD_PIO +: 3];
			end
			if (avs_writedata[AIT_MD_UDMA +: 3] != 3'h0 && avs_writedata[AIT_MD_UDMA +: 3] <= AIT_UDMA_MAX) begin
				mode_r.udma <= avs_writedata[AIT_MD_UDMA +: 3];
				mode_r.mdma <= 3'h0;
			end else if (avs_writedata[AIT_MD_MDMA +: 3] != 3'h0 && avs_writedata[AIT_MD_MDMA +: 3] <= AIT_MDMA_CAP) begin
				mode_r.mdma <= avs_writedata[AIT_MD_MDMA +: 3];
				mode_r.udma <= 3'h0;
			end
		end
	end

	// Command sequencer
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			op_r    <= 8'h00;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (cmd_acc) begin
						op_r    <= avs_writedata[7:0];
						state_r <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					state_r <= (op_r == AIT_OP_RDBUF) ? ST_XFER : ST_IDLE;
				end
				ST_XFER: begin
					if (fifo_push && xfer_idx_r == 8'hFF) begin
						state_r <= ST_FIN;
					end
				end
				default: begin
					// Hold off new commands until the host has drained the data
					if (!fifo_out_valid) begin
						state_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Geometry adopted only from sector count and head field
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			geo_sec_r  <= 8'h00;
			geo_head_r <= 5'h00;
		end else if (state_r == ST_EXEC && op_r == AIT_OP_INIT) begin
			geo_sec_r  <= tf_r.scnt;
			geo_head_r <= {1'b0, tf_r.drhd[3:0]} + 5'h01;
		end
	end

	// Abort flag, cleared by each new command
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			abrt_r <= 1'b0;
		end else if (cmd_acc) begin
			abrt_r <= 1'b0;
		end else if (state_r == ST_EXEC) begin
			// Unknown opcodes abort too, as NOP always does
			abrt_r <= !(is_idle(op_r) || is_imm(op_r) || op_r == AIT_OP_INIT ||
				op_r == AIT_OP_RDBUF || op_r == AIT_OP_RDDMA);
		end
	end

	// Interrupt after busy drops or data is ready; a set beats a status-read clear
	always_comb begin
		intrq_nxt = intrq_r;
		if (rd_hit && avs_address == AIT_REG_STAT) begin
			intrq_nxt = 1'b0;
		end
		if (state_r == ST_EXEC) begin
			intrq_nxt = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			intrq_r <= 1'b0;
		end else begin
			intrq_r <= intrq_nxt;
		end
	end

	// Tick divider runs only while a countdown is live
	// A new command restarts it, so a re-armed timer never gets a short first tick
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tick_cnt_r <= 32'h0000_0000;
		end else if (state_r == ST_EXEC || pwr_r != PW_IDLE || !apd_en_r || tick) begin
			tick_cnt_r <= 32'h0000_0000;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
		end
	end

	// Power state and automatic power-down timer
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pwr_r     <= PW_ACTIVE;
			apd_en_r  <= 1'b0;
			pd_left_r <= 8'h00;
		end else if (state_r == ST_EXEC) begin
			if (is_idle(op_r)) begin
				pwr_r     <= PW_IDLE;
				apd_en_r  <= tf_r.scnt != 8'h00;
				pd_left_r <= tf_r.scnt;
			end else if (is_imm(op_r)) begin
				pwr_r <= PW_IDLE;
			end else begin
				pwr_r <= PW_ACTIVE;
			end
		end else if (pwr_r == PW_IDLE && apd_en_r && tick) begin
			// Counts in whole ticks, so the wait is count times 5 ms
			if (pd_left_r == 8'h01) begin
				pwr_r <= PW_STBY;
			end
			pd_left_r <= pd_left_r - 8'h01;
		end
	end

	// Sector buffer fill by the host while no command runs
	always_ff @(posedge sys_clk) begin
		if (wr_hit && avs_address == AIT_REG_DATA && state_r == ST_IDLE) begin
			buf_mem[buf_wptr_r] <= avs_writedata[15:0];
		end
	end

	// Buffer pointers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			buf_wptr_r <= 8'h00;
			xfer_idx_r <= 8'h00;
		end else begin
			if (wr_hit && avs_address == AIT_REG_DATA && state_r == ST_IDLE) begin
				buf_wptr_r <= buf_wptr_r + 8'h01;
			end
			if (state_r == ST_EXEC) begin
				xfer_idx_r <= 8'h00;
			end else if (fifo_push) begin
				xfer_idx_r <= xfer_idx_r + 8'h01;
			end
		end
	end

	// Read DMA setup: LBA from four registers, zero count is 256
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dma_start_r <= 1'b0;
			dma_req_r   <= '0;
		end else begin
			dma_start_r <= state_r == ST_EXEC && op_r == AIT_OP_RDDMA;
			if (state_r == ST_EXEC && op_r == AIT_OP_RDDMA) begin
				dma_req_r.lba <= {tf_r.drhd[3:0], tf_r.cyhi, tf_r.cylo, tf_r.snum};
				dma_req_r.cnt <= (tf_r.scnt == 8'h00) ? AIT_FULL_CNT : {1'b0, tf_r.scnt};
			end
		end
	end

	// Data FIFO between the sector buffer and the data register
	ait_fifo #(
		.WIDTH (AIT_FIFO_W),
		.DEPTH (AIT_FIFO_D)
	) u_fifo (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.in_valid  (state_r == ST_XFER),
		.in_ready  (fifo_in_ready),
		.in_data   (buf_mem[xfer_idx_r]),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	sequence s_busy_then_idle;
		dev_busy ##1 (!dev_busy && intrq_r && pwr_idle);
	endsequence

	a_idle_sequence: assert property (@(posedge sys_clk) disable iff (rst)
		(cmd_acc && is_idle(avs_writedata[7:0])) |-> ##1 s_busy_then_idle)
		else $error("idle command sequence wrong");
	a_imm_sequence: assert property (@(posedge sys_clk) disable iff (rst)
		(cmd_acc && is_imm(avs_writedata[7:0])) |-> ##1 s_busy_then_idle ##0 $stable(apd_en_r))
		else $error("idle immediate sequence wrong");
	a_apd_armed: assert property (@(posedge sys_clk) disable iff (rst)
		(cmd_acc && is_idle(avs_writedata[7:0]) && tf_r.scnt != 8'h00) |->
		##2 (apd_en_r && pd_left_r == $past(tf_r.scnt, 2)))
		else $error("power-down timer not armed");
	a_apd_off: assert property (@(posedge sys_clk) disable iff (rst)
		(cmd_acc && is_idle(avs_writedata[7:0]) && tf_r.scnt == 8'h00) |-> ##2 !apd_en_r)
		else $error("power-down timer not disabled");
	a_geom_taken: assert property (@(posedge sys_clk) disable iff (rst)
		(cmd_acc && avs_writedata[7:0] == AIT_OP_INIT) |->
		##2 (geo_sec_r == $past(tf_r.scnt, 2) && geo_head_r == {1'b0, $past(tf_r.drhd[3:0], 2)} + 5'h01))
		else $error("geometry not adopted");
	a_nop_abort: assert property (@(posedge sys_clk) disable iff (rst)
		(cmd_acc && avs_writedata[7:0] == AIT_OP_NOP) |-> ##2 (abrt_r && intrq_r))
		else $error("nop did not abort");
	a_rdbuf_drq: assert property (@(posedge sys_clk) disable iff (rst)
		(cmd_acc && avs_writedata[7:0] == AIT_OP_RDBUF) |-> ##2 (state_r == ST_XFER && !abrt_r))
		else $error("read buffer did not start");
	a_dma_setup: assert property (@(posedge sys_clk) disable iff (rst)
		(cmd_acc && avs_writedata[7:0] == AIT_OP_RDDMA) |->
		##2 (dma_start && dma_req_r.lba == {$past(tf_r.drhd[3:0], 2), $past(tf_r.cyhi, 2),
		$past(tf_r.cylo, 2), $past(tf_r.snum, 2)}) ##1 !dma_start)
		else $error("dma setup wrong");
	a_dma_full: assert property (@(posedge sys_clk) disable iff (rst)
		(cmd_acc && avs_writedata[7:0] == AIT_OP_RDDMA && tf_r.scnt == 8'h00) |-> ##2 dma_req_r.cnt == AIT_FULL_CNT)
		else $error("zero count not 256");
	a_mode_single: assert property (@(posedge sys_clk) disable iff (rst)
		!(mode_r.udma != 3'h0 && mode_r.mdma != 3'h0))
		else $error("two dma modes selected");
	a_id163_map: assert property (@(posedge sys_clk) disable iff (rst)
		(avs_read && !ack_r && avs_address == AIT_REG_ID163) |->
		##1 (rdata_r[15:12] == 4'h0 && rdata_r[11:9] == $past(mode_r.mdma) && rdata_r[2:0] == AIT_PIO_CAP))
		else $error("word 163 layout wrong");
	a_id164_map: assert property (@(posedge sys_clk) disable iff (rst)
		(avs_read && !ack_r && avs_address == AIT_REG_ID164) |->
		##1 (rdata_r[15:6] == 10'h000 && rdata_r[5:3] == AIT_MEM_CAP && rdata_r[2:0] == AIT_IO_CAP))
		else $error("word 164 layout wrong");
endmodule : ait_top

// [sim/ait_host_model.sv]
`timescale 1ns/1ps
// Host controller: runs register cycles and watches the DMA request port
module ait_host_model
	import ait_pkg::*;
(
	// Clock
	input  wire logic              sys_clk,
	// Avalon master side
	output logic [3:0]             avs_address,
	output logic                   avs_read,
	output logic                   avs_write,
	output logic [31:0]            avs_writedata,
	output logic [3:0]             avs_byteenable,
	input  wire logic [31:0]       avs_readdata,
	input  wire logic              avs_waitrequest,
	// DMA request watch
	input  wire logic              dma_start,
	input  wire ait_pkg::ait_dma_t dma_req
);
	int       dma_seen = 0; // Start pulses seen
	ait_dma_t dma_last;     // Request carried by the last pulse
	initial begin
		avs_address    = 4'h0;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h0;
		avs_byteenable = 4'hF;
	end
	// Pre-edge values are seen here, so the pulse is never missed
	always @(posedge sys_clk) begin
		if (dma_start === 1'b1) begin
			dma_seen++;
			dma_last = dma_req;
		end
	end
	// Hold the request until the edge that sees waitrequest low
	task automatic finish_cycle;
		int n;
		n = 0;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0 && n < 100) begin
			@(posedge sys_clk);
			n++;
		end
		if (n == 100) tb_top.final_report(1);
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : finish_cycle
	// One edge passes first so a release never meets a new request
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= 1'b1;
		finish_cycle();
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_read    <= 1'b1;
		finish_cycle();
		d = avs_readdata;
	endtask : rd
endmodule : ait_host_model

// [sim/tb_top.sv]
`timescale 1ns/1ps
// Register-level bench; short power-down tick keeps the run brief
module tb_top;
	import ait_pkg::*;
	logic              sys_clk = 1'b0; // 10 MHz clock
	logic              rst     = 1'b1; // Reset, active high
	logic [3:0]        avs_address;
	logic              avs_read, avs_write, avs_waitrequest;
	logic [31:0]       avs_writedata, avs_readdata, d;
	logic [3:0]        avs_byteenable;
	logic              host_intrq, dev_busy, pwr_idle, pwr_standby, dma_start;
	ait_dma_t          dma_req;
	int                bad_count = 0, comparisons = 0, n;
	always #50 sys_clk = ~sys_clk;
	ait_top #(.TICK_CYC(10)) dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.host_intrq(host_intrq), .dev_busy(dev_busy), .pwr_idle(pwr_idle), .pwr_standby(pwr_standby),
		.dma_start(dma_start), .dma_req(dma_req));
	ait_host_model host (.sys_clk(sys_clk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dma_start(dma_start), .dma_req(dma_req));
	// Compare one result, four-state exact
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	// Issue a command, wait for its interrupt, return status
	task automatic cmd(input logic [7:0] op, output logic [31:0] st);
		int k;
		host.wr(AIT_REG_CMD, {24'h0, op});
		#1 chk({31'h0, dev_busy}, 32'h1);
		k = 0;
		while (host_intrq !== 1'b1 && k < 50) begin
			@(posedge sys_clk);
			#1 k++;
		end
		if (k == 50) final_report(1);
		host.rd(AIT_REG_STAT, st);
	endtask : cmd
	// Counts, verdict, end of run
	task automatic final_report(input int hung);
		bad_count += hung;
		$display("checks %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : final_report
	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		// Identify words and mode selection
		host.rd(AIT_REG_ID164, d); chk(d, 32'h1B);
		host.wr(AIT_REG_MODE, 32'h0A);
		host.rd(AIT_REG_ID163, d); chk(d, 32'h292);
		host.wr(AIT_REG_MODE, 32'h4A);
		host.rd(AIT_REG_MODE, d); chk(d, 32'h42);
		host.rd(AIT_REG_ID163, d); chk(d, 32'h092);
		host.wr(AIT_REG_MODE, 32'h0A);
		host.rd(AIT_REG_MODE, d); chk(d, 32'h0A);
		$display("test modes done");
		// Idle with timer, then standby after three ticks
		host.wr(AIT_REG_SCNT, 32'h3);
		cmd(AIT_OP_IDLE_A, d); chk(d & 32'h580, 32'h500);
		chk({31'h0, pwr_idle}, 32'h1);
		n = 0;
		while (pwr_standby !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			#1 n++;
		end
		chk({31'h0, n >= 15 && n <= 40}, 32'h1);
		host.wr(AIT_REG_SCNT, 32'h0);
		cmd(AIT_OP_IDLE_B, d); chk(d & 32'h580, 32'h100);
		repeat (100) @(posedge sys_clk);
		chk({31'h0, pwr_standby}, 32'h0);
		// Idle immediate ignores a nonzero count
		host.wr(AIT_REG_SCNT, 32'h5);
		cmd(AIT_OP_IMM_A, d); chk(d & 32'h580, 32'h100);
		cmd(AIT_OP_IMM_B, d); chk(d & 32'h580, 32'h100);
		$display("test idle done");
		// Geometry with junk in the unused registers
		host.wr(AIT_REG_SCNT, 32'h3F);
		host.wr(AIT_REG_DRHD, 32'h0E);
		for (int r = 2; r <= 6; r++) if (r != 5) host.wr(4'(r), 32'hFF);
		cmd(AIT_OP_INIT, d);
		host.rd(AIT_REG_GEOM, d); chk(d, 32'h0F3F);
		cmd(AIT_OP_NOP, d); chk(d & 32'h1, 32'h1);
		host.rd(AIT_REG_ERR, d); chk(d & 32'h4, 32'h4);
		$display("test geometry and nop done");
		// DMA read with zero count
		host.wr(AIT_REG_DRHD, 32'h05);
		host.wr(AIT_REG_CYHI, 32'h12);
		host.wr(AIT_REG_CYLO, 32'h34);
		host.wr(AIT_REG_SNUM, 32'h56);
		host.wr(AIT_REG_SCNT, 32'h0);
		cmd(AIT_OP_RDDMA, d);
		host.rd(AIT_REG_DLBA, d); chk(d, 32'h5123456);
		host.rd(AIT_REG_DCNT, d); chk(d, 32'h100);
		chk(32'(host.dma_seen), 32'h1);
		chk({4'h0, host.dma_last.lba}, 32'h5123456);
		chk({23'h0, host.dma_last.cnt}, 32'h100);
		$display("test dma done");
		// Fill the buffer, stall so the FIFO refuses, then drain all
		for (int i = 0; i < 256; i++) host.wr(AIT_REG_DATA, 32'(16'h1200 + i));
		cmd(AIT_OP_RDBUF, d);
		repeat (40) @(posedge sys_clk);
		for (int i = 0; i < 256; i++) begin
			host.rd(AIT_REG_DATA, d); chk(d, 32'(16'h1200 + i));
		end
		host.rd(AIT_REG_DATA, d); chk(d, 32'h0);
		host.rd(AIT_REG_STAT, d); chk(d & 32'h8, 32'h0);
		$display("test read buffer done");
		final_report(0);
	end
endmodule : tb_top
